// [hw/scsic_pkg.sv]
package scsic_pkg;
    localparam logic [6:0] CMD_NOP = 7'h00;
    localparam logic [6:0] CMD_FLUSH = 7'h01;
    localparam logic [6:0] CMD_CHIP_RST = 7'h02;
    localparam logic [6:0] CMD_BUS_RST = 7'h03;
    localparam logic [6:0] CMD_RESEL = 7'h40;
    localparam logic [6:0] CMD_SEL = 7'h41;
    localparam logic [6:0] CMD_SEL_ATN = 7'h42;
    localparam logic [6:0] CMD_SEL_STOP = 7'h43;
    localparam logic [6:0] CMD_EN_SEL = 7'h44;
    localparam logic [6:0] CMD_DIS_SEL = 7'h45;
    localparam logic [6:0] CMD_SEL_ATN3 = 7'h46;
    localparam logic [6:0] CMD_RESEL3 = 7'h47;
    localparam int CMD_DMA_BIT = 7;

    localparam int INT_BUS_RST = 7;
    localparam int INT_ILLEGAL = 6;
    localparam int INT_DISC = 5;
    localparam int INT_BUS_SVC = 4;
    localparam int INT_FUNC_DONE = 3;

    localparam logic [2:0] STEP_000 = 3'h0;
    localparam logic [2:0] STEP_001 = 3'h1;
    localparam logic [2:0] STEP_010 = 3'h2;
    localparam logic [2:0] STEP_011 = 3'h3;
    localparam logic [2:0] STEP_100 = 3'h4;

    localparam logic [2:0] PHASE_CMD = 3'h2;
    localparam logic [2:0] PHASE_MSG_OUT = 3'h6;

    localparam int RST_PULSE_CLKS = 130;
    localparam logic [2:0] CCF_ZERO_FACTOR = 3'h0;
    localparam int CCF_ZERO_AS = 8;
    localparam int CNT_W = 24;
    localparam logic [1:0] ATN3_MSG_BYTES = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARB = 3'b001,
        ST_SEL = 3'b010,
        ST_MSG_WAIT = 3'b011,
        ST_MSG = 3'b100,
        ST_CMD_WAIT = 3'b101,
        ST_CMD = 3'b110
    } scsic_state_t;
endpackage : scsic_pkg

// [hw/scsic_rst_timer.sv]
`timescale 1ns/10ps
module scsic_rst_timer #(
    parameter int PULSE_CLKS = scsic_pkg::RST_PULSE_CLKS
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clr_i,
    input wire logic start_i,
    input wire logic [2:0] clock_conversion_factor_i,
    output logic bus_reset_output_o
);
    typedef struct packed {
        logic [10:0] cnt;
        logic active;
    } scsic_tmr_t;

    scsic_tmr_t s_q;
    scsic_tmr_t s_d;
    logic [10:0] factor;

    always_comb begin
        // Factor zero stands for eight
        if (clock_conversion_factor_i == scsic_pkg::CCF_ZERO_FACTOR) begin
            factor = 11'(scsic_pkg::CCF_ZERO_AS);
        end else begin
            factor = {8'h00, clock_conversion_factor_i};
        end
        s_d = s_q;
        if (clr_i) begin
            s_d = '0;
        end else if (start_i) begin
            s_d.active = 1'b1;
            s_d.cnt = 11'(11'(PULSE_CLKS) * factor - 11'h001);
        end else if (s_q.active) begin
            if (s_q.cnt == 11'h000) begin
                s_d.active = 1'b0;
            end else begin
                s_d.cnt = s_q.cnt - 11'h001;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_reset_output_o = s_q.active;
endmodule : scsic_rst_timer

// [hw/scsic_ctrl.sv]
`timescale 1ns/10ps
module scsic_ctrl (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Command port
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic [scsic_pkg::CNT_W-1:0] xfer_count_i,
    input wire logic [2:0] clock_conversion_factor_i,
    input wire logic reset_report_en_i,
    input wire logic [4:0] fifo_level_i,
    input wire logic int_clr_i,
    // Bus engine events
    input wire logic bus_reset_input_i,
    input wire logic arb_won_i,
    input wire logic sel_done_i,
    input wire logic sel_timeout_i,
    input wire logic req_i,
    input wire logic [2:0] phase_i,
    input wire logic byte_ack_i,
    input wire logic disconnect_i,
    // Outputs
    output logic cmd_busy_o,
    output logic [7:0] cmd_reg_o,
    output logic [scsic_pkg::CNT_W-1:0] xfer_cnt_o,
    output logic fifo_flush_o,
    output logic bus_reset_output_o,
    output logic arb_req_o,
    output logic sel_o,
    output logic resel_o,
    output logic atn_o,
    output logic xfer_o,
    output logic dma_req_o,
    output logic connected_o,
    output logic sel_en_o,
    output logic [7:0] int_status_o,
    output logic [2:0] seq_step_o
);
    typedef struct packed {
        scsic_pkg::scsic_state_t st;
        logic [7:0] cmd;
        logic locked;
        logic connected;
        logic sel_en;
        logic atn;
        logic dma;
        logic resel;
        logic stop_after_msg;
        logic [1:0] msg_left;
        logic [scsic_pkg::CNT_W-1:0] cmd_left;
        logic [scsic_pkg::CNT_W-1:0] xfer_cnt;
        logic [7:0] ints;
        logic [2:0] step;
        logic flush;
        logic rst_go;
        logic rst_in;
        logic soft_rst;
    } scsic_ctrl_t;

    scsic_ctrl_t s_q;
    scsic_ctrl_t s_d;
    logic [6:0] code;
    logic is_dma;
    logic is_disc_cmd;
    logic [7:0] int_set;
    logic [scsic_pkg::CNT_W-1:0] src_cnt;

    assign code = cmd_i[6:0];
    assign is_dma = cmd_i[scsic_pkg::CMD_DMA_BIT];
    assign is_disc_cmd = (code >= scsic_pkg::CMD_RESEL) && (code <= scsic_pkg::CMD_RESEL3);
    assign src_cnt = is_dma ? s_q.xfer_cnt : {19'h00000, fifo_level_i};

    always_comb begin
        s_d = s_q;
        int_set = 8'h00;
        s_d.flush = 1'b0;
        s_d.rst_go = 1'b0;
        s_d.soft_rst = 1'b0;
        s_d.rst_in = bus_reset_input_i;
        // Looped-back or external bus reset
        if (bus_reset_input_i && !s_q.rst_in && reset_report_en_i) begin
            int_set[scsic_pkg::INT_BUS_RST] = 1'b1;
        end
        if (disconnect_i) begin
            s_d.connected = 1'b0;
            s_d.atn = 1'b0;
        end
        if (s_q.dma && byte_ack_i && s_q.xfer_cnt != '0) begin
            s_d.xfer_cnt = s_q.xfer_cnt - 24'h000001;
        end

        // Sequencer
        unique case (s_q.st)
            scsic_pkg::ST_IDLE: begin
            end
            scsic_pkg::ST_ARB: begin
                if (arb_won_i) begin
                    s_d.st = scsic_pkg::ST_SEL;
                end
            end
            scsic_pkg::ST_SEL: begin
                if (sel_timeout_i) begin
                    // Early end, bus left disconnected
                    s_d.st = scsic_pkg::ST_IDLE;
                    s_d.step = scsic_pkg::STEP_000;
                    s_d.atn = 1'b0;
                    s_d.connected = 1'b0;
                    int_set[scsic_pkg::INT_DISC] = 1'b1;
                end else if (sel_done_i) begin
                    s_d.connected = 1'b1;
                    if (s_q.resel) begin
                        s_d.st = scsic_pkg::ST_MSG;
                    end else if (s_q.atn) begin
                        s_d.st = scsic_pkg::ST_MSG_WAIT;
                    end else begin
                        s_d.st = scsic_pkg::ST_CMD_WAIT;
                    end
                end
            end
            scsic_pkg::ST_MSG_WAIT: begin
                if (req_i) begin
                    if (phase_i == scsic_pkg::PHASE_MSG_OUT) begin
                        s_d.st = scsic_pkg::ST_MSG;
                    end else begin
                        // ATN stays driven here
                        s_d.st = scsic_pkg::ST_IDLE;
                        s_d.step = scsic_pkg::STEP_000;
                        int_set[scsic_pkg::INT_FUNC_DONE] = 1'b1;
                        int_set[scsic_pkg::INT_BUS_SVC] = 1'b1;
                    end
                end
            end
            scsic_pkg::ST_MSG: begin
                if (byte_ack_i) begin
                    if (s_q.resel) begin
                        s_d.st = scsic_pkg::ST_IDLE;
                        int_set[scsic_pkg::INT_FUNC_DONE] = 1'b1;
                    end else if (s_q.msg_left > 2'h1) begin
                        s_d.msg_left = s_q.msg_left - 2'h1;
                    end else if (s_q.stop_after_msg) begin
                        s_d.st = scsic_pkg::ST_IDLE;
                        s_d.step = scsic_pkg::STEP_001;
                        int_set[scsic_pkg::INT_FUNC_DONE] = 1'b1;
                        int_set[scsic_pkg::INT_BUS_SVC] = 1'b1;
                    end else begin
                        s_d.atn = 1'b0;
                        s_d.st = scsic_pkg::ST_CMD_WAIT;
                    end
                end
            end
            scsic_pkg::ST_CMD_WAIT: begin
                if (req_i) begin
                    if (phase_i == scsic_pkg::PHASE_CMD) begin
                        s_d.st = scsic_pkg::ST_CMD;
                    end else begin
                        s_d.st = scsic_pkg::ST_IDLE;
                        s_d.step = scsic_pkg::STEP_010;
                        int_set[scsic_pkg::INT_FUNC_DONE] = 1'b1;
                        int_set[scsic_pkg::INT_BUS_SVC] = 1'b1;
                    end
                end
            end
            scsic_pkg::ST_CMD: begin
                if (byte_ack_i) begin
                    if (s_q.cmd_left <= 24'h000001) begin
                        s_d.st = scsic_pkg::ST_IDLE;
                        s_d.step = scsic_pkg::STEP_100;
                        int_set[scsic_pkg::INT_FUNC_DONE] = 1'b1;
                        int_set[scsic_pkg::INT_BUS_SVC] = 1'b1;
                    end else begin
                        s_d.cmd_left = s_q.cmd_left - 24'h000001;
                    end
                end else if (req_i && phase_i != scsic_pkg::PHASE_CMD) begin
                    s_d.st = scsic_pkg::ST_IDLE;
                    s_d.step = scsic_pkg::STEP_011;
                    int_set[scsic_pkg::INT_FUNC_DONE] = 1'b1;
                    int_set[scsic_pkg::INT_BUS_SVC] = 1'b1;
                end
            end
            default: begin
                s_d.st = scsic_pkg::ST_IDLE;
            end
        endcase

        // Command decode
        if (cmd_wr_i) begin
            s_d.cmd = cmd_i;
            if (s_q.locked) begin
                // Only a no-op frees the command register after reset
                if (code == scsic_pkg::CMD_NOP) begin
                    s_d.locked = 1'b0;
                    if (is_dma) begin
                        s_d.xfer_cnt = xfer_count_i;
                    end
                end
                s_d.cmd = 8'h00;
            end else if (!is_disc_cmd) begin
                // Accepted regardless of bus state
                unique case (code)
                    scsic_pkg::CMD_NOP: begin
                        if (is_dma) begin
                            s_d.xfer_cnt = xfer_count_i;
                        end
                    end
                    scsic_pkg::CMD_FLUSH: begin
                        s_d.flush = 1'b1;
                    end
                    scsic_pkg::CMD_CHIP_RST: begin
                        s_d.soft_rst = 1'b1;
                    end
                    scsic_pkg::CMD_BUS_RST: begin
                        s_d.rst_go = 1'b1;
                    end
                    default: begin
                        s_d.cmd = 8'h00;
                        int_set[scsic_pkg::INT_ILLEGAL] = 1'b1;
                    end
                endcase
            end else if (s_q.connected || s_q.st != scsic_pkg::ST_IDLE ||
                         (is_dma && code == scsic_pkg::CMD_DIS_SEL)) begin
                s_d.cmd = 8'h00;
                int_set[scsic_pkg::INT_ILLEGAL] = 1'b1;
            end else begin
                s_d.dma = is_dma;
                s_d.resel = 1'b0;
                s_d.atn = 1'b0;
                s_d.stop_after_msg = 1'b0;
                s_d.msg_left = 2'h1;
                s_d.cmd_left = src_cnt;
                s_d.step = scsic_pkg::STEP_000;
                unique case (code)
                    scsic_pkg::CMD_EN_SEL: begin
                        s_d.sel_en = 1'b1;
                    end
                    scsic_pkg::CMD_DIS_SEL: begin
                        s_d.sel_en = 1'b0;
                    end
                    scsic_pkg::CMD_RESEL, scsic_pkg::CMD_RESEL3: begin
                        s_d.sel_en = 1'b0;
                        s_d.resel = 1'b1;
                        s_d.st = scsic_pkg::ST_ARB;
                    end
                    scsic_pkg::CMD_SEL: begin
                        s_d.sel_en = 1'b0;
                        s_d.st = scsic_pkg::ST_ARB;
                    end
                    default: begin
                        // Select with ATN variants
                        s_d.sel_en = 1'b0;
                        s_d.atn = 1'b1;
                        s_d.st = scsic_pkg::ST_ARB;
                        s_d.stop_after_msg = (code == scsic_pkg::CMD_SEL_STOP);
                        if (code == scsic_pkg::CMD_SEL_ATN3) begin
                            s_d.msg_left = scsic_pkg::ATN3_MSG_BYTES;
                        end
                        // Message bytes are not part of the command count
                        if (src_cnt > {22'h000000, s_d.msg_left}) begin
                            s_d.cmd_left = src_cnt - {22'h000000, s_d.msg_left};
                        end else begin
                            s_d.cmd_left = 24'h000001;
                        end
                    end
                endcase
            end
        end

        // Sticky flags: a new event wins over the clear
        s_d.ints = (int_clr_i ? 8'h00 : s_q.ints) | int_set;
        if (s_q.st == scsic_pkg::ST_IDLE && s_d.st == scsic_pkg::ST_IDLE && s_q.cmd != 8'h00 &&
            !cmd_wr_i) begin
            s_d.cmd = 8'h00;
        end

        // Chip reset returns everything to the reset values except rst_in, which samples the bus reset input
        if (s_q.soft_rst) begin
            s_d = '0;
            s_d.locked = 1'b1;
            s_d.rst_in = bus_reset_input_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
            s_q.locked <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    scsic_rst_timer #(
        .PULSE_CLKS(scsic_pkg::RST_PULSE_CLKS)
    ) u_rst_timer (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .clr_i(s_q.soft_rst),
        .start_i(s_q.rst_go),
        .clock_conversion_factor_i(clock_conversion_factor_i),
        .bus_reset_output_o(bus_reset_output_o)
    );

    assign cmd_busy_o = s_q.locked || s_q.st != scsic_pkg::ST_IDLE;
    assign cmd_reg_o = s_q.cmd;
    assign xfer_cnt_o = s_q.xfer_cnt;
    assign fifo_flush_o = s_q.flush;
    assign arb_req_o = s_q.st == scsic_pkg::ST_ARB;
    assign sel_o = s_q.st == scsic_pkg::ST_SEL && !s_q.resel;
    assign resel_o = s_q.st == scsic_pkg::ST_SEL && s_q.resel;
    assign atn_o = s_q.atn;
    assign xfer_o = s_q.st == scsic_pkg::ST_MSG || s_q.st == scsic_pkg::ST_CMD;
    assign dma_req_o = xfer_o && s_q.dma;
    assign connected_o = s_q.connected;
    assign sel_en_o = s_q.sel_en;
    assign int_status_o = s_q.ints;
    assign seq_step_o = s_q.step;
endmodule : scsic_ctrl

// [sim/scsic_ctrl_checker.sv]
`timescale 1ns/10ps
module scsic_ctrl_checker (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic [scsic_pkg::CNT_W-1:0] xfer_count_i,
    input wire logic [2:0] clock_conversion_factor_i,
    input wire logic reset_report_en_i,
    input wire logic bus_reset_input_i,
    input wire logic arb_won_i,
    input wire logic sel_timeout_i,
    input wire logic byte_ack_i,
    input wire logic cmd_busy_o,
    input wire logic [7:0] cmd_reg_o,
    input wire logic [scsic_pkg::CNT_W-1:0] xfer_cnt_o,
    input wire logic fifo_flush_o,
    input wire logic bus_reset_output_o,
    input wire logic arb_req_o,
    input wire logic sel_o,
    input wire logic resel_o,
    input wire logic atn_o,
    input wire logic xfer_o,
    input wire logic connected_o,
    input wire logic [7:0] int_status_o,
    input wire logic [2:0] seq_step_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [10:0] hi_q;
    logic [10:0] exp_q;
    // Width of the bus reset pulse against the factor seen before it rose
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_q <= 11'h000;
            exp_q <= 11'h000;
        end else if (!bus_reset_output_o) begin
            hi_q <= 11'h000;
            exp_q <= 11'(scsic_pkg::RST_PULSE_CLKS) *
                (clock_conversion_factor_i == 3'h0 ? 11'h008 : {8'h00, clock_conversion_factor_i});
        end else begin
            hi_q <= hi_q + 11'h001;
        end
    end
    sequence s_arb_won;
        arb_req_o && arb_won_i;
    endsequence
    sequence s_sel_done;
        $fell(cmd_busy_o) && seq_step_o == scsic_pkg::STEP_100;
    endsequence
    a_nop_no_int:
    assert property (cmd_wr_i && cmd_i[6:0] == scsic_pkg::CMD_NOP |=> $stable(int_status_o))
        else $error("no-op changed interrupt flags");
    a_nop_load_cnt:
    assert property (cmd_wr_i && cmd_i == 8'h80 |=> xfer_cnt_o == $past(xfer_count_i))
        else $error("dma no-op did not load counter");
    a_flush_pulse:
    assert property (cmd_wr_i && cmd_i == 8'h01 && !cmd_busy_o |=> fifo_flush_o ##1 !fifo_flush_o)
        else $error("flush pulse wrong");
    a_rst_start:
    assert property (cmd_wr_i && cmd_i == 8'h03 && !cmd_busy_o && !bus_reset_output_o
        |-> ##[1:3] bus_reset_output_o) else $error("bus reset did not start");
    a_rst_width:
    assert property ($fell(bus_reset_output_o) |-> hi_q == exp_q)
        else $error("bus reset width wrong");
    a_rst_int_cause:
    assert property ($rose(int_status_o[scsic_pkg::INT_BUS_RST])
        |-> $past(reset_report_en_i) && $past(bus_reset_input_i)) else $error("bus reset flag without cause");
    a_illegal_conn:
    assert property (cmd_wr_i && cmd_i[6:3] == 4'h8 && connected_o
        |=> int_status_o[scsic_pkg::INT_ILLEGAL] && cmd_reg_o == 8'h00 && connected_o)
        else $error("connected disconnected-group command not refused");
    a_no_dma_dis:
    assert property (cmd_wr_i && cmd_i == 8'hc5 && !cmd_busy_o |=> int_status_o[scsic_pkg::INT_ILLEGAL])
        else $error("dma disable-selection accepted");
    a_sel_timeout:
    assert property (sel_o && sel_timeout_i |=> seq_step_o == scsic_pkg::STEP_000
        && int_status_o[scsic_pkg::INT_DISC] && !connected_o) else $error("selection timeout wrong");
    a_atn_release:
    assert property (atn_o && xfer_o && byte_ack_i && cmd_reg_o[6:0] == scsic_pkg::CMD_SEL_ATN |=> !atn_o)
        else $error("atn kept after message byte");
    a_arb_to_sel:
    assert property (s_arb_won |=> ##[0:3] (sel_o || resel_o)) else $error("no selection after arbitration");
    a_done_ints:
    assert property (s_sel_done |-> ##[0:1] int_status_o[4:3] == 2'h3) else $error("completion flags wrong");
endmodule : scsic_ctrl_checker

bind scsic_ctrl scsic_ctrl_checker i_chk (.*);

// [sim/scsic_bus_model.sv]
`timescale 1ns/10ps
module scsic_bus_model (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] mode_i,
    input wire logic arb_req_i,
    input wire logic sel_i,
    input wire logic resel_i,
    input wire logic atn_i,
    input wire logic xfer_i,
    input wire logic connected_i,
    input wire logic busy_i,
    output logic arb_won_o,
    output logic sel_done_o,
    output logic sel_timeout_o,
    output logic req_o,
    output logic [2:0] phase_o,
    output logic byte_ack_o,
    output logic [7:0] n_ack_o
);
    // Modes: 0 normal, 1 timeout, 2 no message out, 3 no command phase, 4 early phase change
    logic gap_q;
    logic [2:0] ph_q;
    logic [3:0] cmd_n_q;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {gap_q, arb_won_o, sel_done_o, sel_timeout_o, req_o, byte_ack_o} <= 6'h00;
            phase_o <= 3'h5;
            ph_q <= 3'h0;
            cmd_n_q <= 4'h0;
            n_ack_o <= 8'h00;
        end else begin
            {arb_won_o, sel_done_o, sel_timeout_o, req_o, byte_ack_o} <= 5'h00;
            phase_o <= 3'h5;
            gap_q <= busy_i && !gap_q;
            if (!busy_i || gap_q) begin
                ph_q <= ph_q;
            end else if (arb_req_i && !sel_i && !resel_i) begin
                arb_won_o <= 1'b1;
                n_ack_o <= 8'h00;
                cmd_n_q <= 4'h0;
            end else if (sel_i || resel_i) begin
                sel_done_o <= (mode_i != 3'h1);
                sel_timeout_o <= (mode_i == 3'h1);
            end else if (xfer_i && mode_i == 3'h4 && ph_q == scsic_pkg::PHASE_CMD && cmd_n_q == 4'h2) begin
                req_o <= 1'b1;
                phase_o <= 3'h0;
                ph_q <= 3'h0;
            end else if (xfer_i) begin
                byte_ack_o <= 1'b1;
                n_ack_o <= n_ack_o + 8'h01;
                cmd_n_q <= cmd_n_q + {3'h0, ph_q == scsic_pkg::PHASE_CMD};
            end else if (connected_i) begin
                req_o <= 1'b1;
                ph_q <= atn_i ? (mode_i == 3'h2 ? 3'h0 : scsic_pkg::PHASE_MSG_OUT)
                    : (mode_i == 3'h3 ? 3'h0 : scsic_pkg::PHASE_CMD);
                phase_o <= atn_i ? (mode_i == 3'h2 ? 3'h0 : scsic_pkg::PHASE_MSG_OUT)
                    : (mode_i == 3'h3 ? 3'h0 : scsic_pkg::PHASE_CMD);
            end
        end
    end
endmodule : scsic_bus_model

// [sim/scsic_ctrl_tb_top.sv]
`timescale 1ns/10ps
module scsic_ctrl_tb_top;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_wr_i = 1'b0;
    logic [7:0] cmd_i = 8'h00;
    logic [scsic_pkg::CNT_W-1:0] xfer_count_i = 24'h00000c;
    logic [2:0] clock_conversion_factor_i = 3'h2;
    logic reset_report_en_i = 1'b0;
    logic [4:0] fifo_level_i = 5'h00;
    logic int_clr_i = 1'b0;
    logic disconnect_i = 1'b0;
    logic loop = 1'b0;
    logic [2:0] mode = 3'h0;
    logic arb_won_i, sel_done_i, sel_timeout_i, req_i, byte_ack_i;
    logic [2:0] phase_i;
    logic [7:0] n_ack;
    logic cmd_busy_o, fifo_flush_o, bus_reset_output_o, arb_req_o, sel_o, resel_o, atn_o;
    logic xfer_o, dma_req_o, connected_o, sel_en_o;
    logic [7:0] cmd_reg_o, int_status_o;
    logic [scsic_pkg::CNT_W-1:0] xfer_cnt_o;
    logic [2:0] seq_step_o;
    wire logic bus_reset_input_i = loop & bus_reset_output_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic dma_seen = 1'b0;
    always @(posedge core_clk_i) dma_seen <= dma_seen | (dma_req_o === 1'b1);
    scsic_ctrl i_dut (.*);
    scsic_bus_model i_bus (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .mode_i(mode), .arb_req_i(arb_req_o),
        .sel_i(sel_o), .resel_i(resel_o), .atn_i(atn_o), .xfer_i(xfer_o), .connected_i(connected_o),
        .busy_i(cmd_busy_o), .arb_won_o(arb_won_i), .sel_done_o(sel_done_i), .sel_timeout_o(sel_timeout_i),
        .req_o(req_i), .phase_o(phase_i), .byte_ack_o(byte_ack_i), .n_ack_o(n_ack));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] c);
        cyc(1);
        cmd_i = c;
        cmd_wr_i = 1'b1;
        cyc(1);
        cmd_wr_i = 1'b0;
    endtask : wr
    task automatic clr();
        int_clr_i = 1'b1;
        cyc(1);
        int_clr_i = 1'b0;
        cyc(1);
    endtask : clr
    task automatic run(input logic [7:0] c, input logic [4:0] lv, input logic [2:0] m,
        input logic [2:0] st, input logic [7:0] it, input logic [7:0] na);
        fifo_level_i = lv;
        mode = m;
        wr(c);
        for (int i = 0; i < 400 && cmd_busy_o !== 1'b0; i++) cyc(1);
        chk("int_status", int_status_o, it);
        if (st != 3'h7) chk("seq_step", seq_step_o, st);
        if (st != 3'h7) chk("byte_count", n_ack, na);
        if (connected_o === 1'b1) begin
            disconnect_i = 1'b1;
            cyc(1);
            disconnect_i = 1'b0;
        end
        clr();
    endtask : run
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (50000) @(posedge core_clk_i);
        n_mismatch++;
        final_report();
    end
    initial begin
        int n;
        cyc(10);
        nrst_i = 1'b1;
        chk("busy_locked", cmd_busy_o, 1'b1);
        wr(8'h01);
        chk("flush_locked", fifo_flush_o, 1'b0);
        wr(8'h80);
        chk("busy_free", cmd_busy_o, 1'b0);
        chk("xfer_cnt", xfer_cnt_o, 24'h00000c);
        chk("nop_int", int_status_o, 8'h00);
        wr(8'h01);
        chk("flush", fifo_flush_o, 1'b1);
        cyc(1);
        chk("flush_end", fifo_flush_o, 1'b0);
        for (int k = 0; k < 2; k++) begin
            clock_conversion_factor_i = (k == 0) ? 3'h2 : 3'h0;
            reset_report_en_i = k[0];
            loop = 1'b1;
            wr(8'h03);
            n = 0;
            for (int i = 0; i < 4 && bus_reset_output_o !== 1'b1; i++) cyc(1);
            for (int i = 0; i < 1100 && bus_reset_output_o === 1'b1; i++) begin
                n++;
                cyc(1);
            end
            chk("rst_width", n, scsic_pkg::RST_PULSE_CLKS * ((k == 0) ? 2 : 8));
            chk("rst_int", int_status_o[scsic_pkg::INT_BUS_RST], k[0]);
            clr();
        end
        wr(8'hc5);
        chk("dma_dis_sel", int_status_o[scsic_pkg::INT_ILLEGAL], 1'b1);
        clr();
        wr(8'h44);
        chk("sel_en", sel_en_o, 1'b1);
        wr(8'h45);
        chk("sel_dis", sel_en_o, 1'b0);
        run(8'h42, 5'h07, 3'h0, scsic_pkg::STEP_100, 8'h18, 8'h07);
        run(8'h41, 5'h0a, 3'h0, scsic_pkg::STEP_100, 8'h18, 8'h0a);
        run(8'h42, 5'h07, 3'h1, scsic_pkg::STEP_000, 8'h20, 8'h00);
        run(8'h42, 5'h07, 3'h3, scsic_pkg::STEP_010, 8'h18, 8'h01);
        run(8'h41, 5'h0a, 3'h3, scsic_pkg::STEP_010, 8'h18, 8'h00);
        run(8'h42, 5'h07, 3'h4, scsic_pkg::STEP_011, 8'h18, 8'h03);
        run(8'h41, 5'h06, 3'h4, scsic_pkg::STEP_011, 8'h18, 8'h02);
        run(8'h43, 5'h07, 3'h0, scsic_pkg::STEP_001, 8'h18, 8'h01);
        run(8'h46, 5'h09, 3'h0, scsic_pkg::STEP_100, 8'h18, 8'h09);
        run(8'h40, 5'h01, 3'h0, 3'h7, 8'h08, 8'h00);
        run(8'h47, 5'h01, 3'h0, 3'h7, 8'h08, 8'h00);
        chk("dma_idle", dma_seen, 1'b0);
        wr(8'h80);
        run(8'hc1, 5'h00, 3'h0, scsic_pkg::STEP_100, 8'h18, 8'h0c);
        chk("dma_req", dma_seen, 1'b1);
        chk("xfer_cnt_end", xfer_cnt_o, 24'h000000);
        fifo_level_i = 5'h07;
        mode = 3'h2;
        wr(8'h42);
        for (int i = 0; i < 400 && cmd_busy_o !== 1'b0; i++) cyc(1);
        chk("nomsg_step", seq_step_o, scsic_pkg::STEP_000);
        chk("nomsg_atn", atn_o, 1'b1);
        clr();
        wr(8'h41);
        chk("illegal", int_status_o[scsic_pkg::INT_ILLEGAL], 1'b1);
        chk("cmd_reg", cmd_reg_o, 8'h00);
        wr(8'h01);
        chk("flush_conn", fifo_flush_o, 1'b1);
        wr(8'h02);
        cyc(1);
        chk("chip_rst_conn", connected_o, 1'b0);
        chk("chip_rst_busy", cmd_busy_o, 1'b1);
        chk("chip_rst_int", int_status_o, 8'h00);
        wr(8'h00);
        chk("unlock", cmd_busy_o, 1'b0);
        final_report();
    end
endmodule : scsic_ctrl_tb_top
